// ===== rtl/lcdc_top.sv
// command decoder and display ram access of the lcd controller
// assumes host pins are asynchronous; display ram sits behind it
`timescale 1ns/1ps
// Functional notes
// [R1] select low means command, high means display data, qualified by strobes
// [R2] host shifts serial bytes most significant bit first
// [R3] AFh turns display on, AEh turns it off
// [R4] display off while all-points-on enters power save
// [R5] 40h..7Fh load start line 0..63 shown on first common row
// [R6] B0h..B8h load page 0..8; page 8 keeps only bit 0
// [R7] page change alters only ram access, never the shown image
// [R8] 10h..18h set column high nibble, 00h..0Fh the low nibble
// [R9] each data access bumps column up to 132, page fixed
// [R10] status bit 7 is busy; commands are rejected while busy; code queues up to two during init and drops only when the buffer is full or the reset pin is low
// [R11] status bit 6 high for normal segment order, low for reversed
// [R12] status bit 5 low when display on, high when off
// [R13] status bit 4 high during initialisation; bits 3..0 read zero
// [R14] data write stores byte at page and column, then column+1
// [R15] one dummy read after column set; no serial data reads
// [R16] A0h normal, A1h reversed segment mapping; column still counts up
// [R17] A6h lights ram ones, A7h lights ram zeros; ram untouched
// [R18] A5h forces all pixels on over reverse; A4h restores
// [R19] all-points-on while display off enters power save
// [R20] A2h and A3h choose between the two bias sets
// [R21] E0h saves column; only writes advance it until end
// [R22] end command leaves mode and restores saved column
// [R23] host pairs E0h with end and sets no column inside
// [R24] E2h clears start, column, page and rmw; ram kept
// [R25] unknown command bytes change nothing
module lcdc_top
  import lcdc_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_HARDWARE_RESET_N,
  input  wire logic       I_SERIAL_MODE,
  input  wire logic       I_CS_N,
  input  wire logic       I_DATA_COMMAND_SELECT,
  input  wire logic       I_RD_N,
  input  wire logic       I_WR_N,
  input  wire logic [7:0] I_DATA,
  input  wire logic       I_SCL,
  input  wire logic       I_SDI,
  output logic      [7:0] O_DATA,
  output logic            O_DATA_OE_N,
  output logic            O_BUSY,
  output lcdc_disp_s      O_DISP
);
  typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT} lcdc_exec_e;

  // pin synchronisers: stage one feeds only stage two
  logic [8:0] s1_q, s2_q, s3_q;   // {hwrst, cs, dcs, rd, wr, scl, sdi, serial, spare}
  wire  [8:0] pins = {I_HARDWARE_RESET_N, I_CS_N, I_DATA_COMMAND_SELECT, I_RD_N, I_WR_N,
                      I_SCL, I_SDI, I_SERIAL_MODE, 1'b0};
  logic [7:0] d1_q, d2_q;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s1_q <= 9'h1F8;
      s2_q <= 9'h1F8;
      s3_q <= 9'h1F8;
      d1_q <= RST_DATA;
      d2_q <= RST_DATA;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= I_DATA;
      d2_q <= d1_q;
    end
  end

  wire hw_rst_n = s2_q[8];
  wire cs_n     = s2_q[7];
  wire dcs      = s2_q[6];
  wire rd_n     = s2_q[5];
  wire ser_mode = s2_q[1];
  wire wr_rise  = s2_q[4] & ~s3_q[4] & ~cs_n & ~ser_mode;
  wire rd_fall  = ~s2_q[5] & s3_q[5] & ~cs_n & ~ser_mode;
  wire rd_rise  = s2_q[5] & ~s3_q[5] & ~cs_n & ~ser_mode;
  wire scl_rise = s2_q[3] & ~s3_q[3] & ~cs_n & ser_mode;

  // serial shifter, msb first; select sampled with the eighth bit
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  wire        ser_done = scl_rise && (bit_q == 3'd7);
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sh_q  <= 7'h00;
      bit_q <= 3'd0;
    end
    else if (cs_n)
      bit_q <= 3'd0;                                  // chip deselect realigns bytes
    else if (scl_rise)
    begin
      sh_q  <= {sh_q[5:0], s2_q[2]};                  // see [R2]
      bit_q <= bit_q + 3'd1;
    end
  end

  // transfer capture into the buffer; reads from the serial side never occur
  lcdc_xfer_s in_x, out_x;
  logic       in_valid, in_ready, out_valid, out_ready;
  assign in_valid = (wr_rise || ser_done || (rd_rise && dcs)) && hw_rst_n;   // see [R15]
  assign in_x     = '{is_data: dcs, is_read: rd_rise,
                      byte_v: ser_done ? {sh_q, s2_q[2]} : d2_q};           // see [R1]

  lcdc_buf2 #(.W($bits(lcdc_xfer_s))) u_buf (
    .i_clk       (I_SYS_CLK),
    .i_rst_n     (I_RST_N),
    .i_in_valid  (in_valid),
    .o_in_ready  (in_ready),
    .i_in_data   (in_x),
    .o_out_valid (out_valid),
    .i_out_ready (out_ready),
    .o_out_data  (out_x)
  );

  // control state
  logic       disp_on_q, seg_nrm_q, invert_q, all_on_q, bias_q, psave_q, rmw_q;
  logic [5:0] start_q;
  logic [3:0] page_q;
  logic [7:0] col_q, col_save_q, rd_lat_q;
  logic       rd_ok_q;                              // column was in range when the read was taken
  logic [7:0] init_cnt_q;
  lcdc_exec_e st_q;

  wire init_act = (init_cnt_q != 8'd0);
  wire busy     = init_act || !in_ready;            // see [R10]
  assign out_ready = (st_q == ST_IDLE) && !init_act && hw_rst_n;
  wire take     = out_valid && out_ready;
  wire [7:0] c  = out_x.byte_v;
  wire is_cmd   = take && !out_x.is_data && !out_x.is_read;
  wire dat_wr   = take && out_x.is_data && !out_x.is_read;
  wire dat_rd   = take && out_x.is_data && out_x.is_read;

  // command decode, one wire per pattern; anything else hits nothing
  wire c_onoff = is_cmd && (c[7:1] == PFX_ONOFF);
  wire c_start = is_cmd && (c[7:6] == PFX_START);
  wire c_page  = is_cmd && (c[7:4] == PFX_PAGE) && (c[3:0] <= NIB_MAX);
  wire c_colhi = is_cmd && (c[7:4] == PFX_COLHI) && (c[3:0] <= NIB_MAX);
  wire c_collo = is_cmd && (c[7:4] == PFX_COLLO);
  wire c_adc   = is_cmd && (c[7:1] == PFX_ADC);
  wire c_rev   = is_cmd && (c[7:1] == PFX_REV);
  wire c_allon = is_cmd && (c[7:1] == PFX_ALLON);
  wire c_bias  = is_cmd && (c[7:1] == PFX_BIAS);
  wire c_rmw   = is_cmd && (c == CMD_RMW);
  wire c_end   = is_cmd && (c == CMD_END) && rmw_q;
  wire c_reset = is_cmd && (c == CMD_RESET);

  // power save follows the display-off plus all-on combination
  wire nxt_on    = c_onoff ? c[0] : disp_on_q;
  wire nxt_allon = c_allon ? c[0] : all_on_q;
  wire nxt_psave = !nxt_on && nxt_allon;             // see [R4] [R19]

  // ram port: page times width plus column; indicator page keeps bit 0 only
  wire        col_ok  = (col_q < COL_STOP);
  wire [10:0] ram_adr = 11'(page_q) * 11'(NUM_COLS) + 11'(col_q);   // full width: page 8 needs 11 bits
  wire        ram_we  = dat_wr && col_ok;
  wire [7:0]  ram_wd  = (page_q == LAST_PAGE) ? {7'h00, c[0]} : c;   // see [R6] [R14]
  wire [7:0]  ram_rd;
  wire        col_bump = col_ok && (dat_wr || (dat_rd && !rmw_q));    // see [R9] [R21]

  lcdc_ram #(.DEPTH(NUM_COLS * NUM_PAGES), .AW(11), .DW(8)) u_ram (
    .i_clk   (I_SYS_CLK),
    .i_we    (ram_we),
    .i_addr  (ram_adr),
    .i_wdata (ram_wd),
    .o_rdata (ram_rd)
  );

  // status byte assembled live, sampled onto the pins at the read edge
  wire [7:0] status = {busy, seg_nrm_q, ~disp_on_q, init_act, 4'h0};  // see [R11] [R12] [R13]

  // init timer: restarted by the reset pin or the reset command
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      init_cnt_q <= 8'(INIT_CYC);
    else if (!hw_rst_n || c_reset)
      init_cnt_q <= 8'(INIT_CYC);                    // see [R13] [R24]
    else if (init_act)
      init_cnt_q <= init_cnt_q - 8'd1;
  end

  // display settings; the pin reset clears all, the command only its own set
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      disp_on_q <= RST_DISP_ON;
      seg_nrm_q <= RST_SEG_NRM;
      invert_q  <= RST_INVERT;
      all_on_q  <= RST_ALL_ON;
      bias_q    <= RST_BIAS;
      psave_q   <= 1'b0;
    end
    else if (!hw_rst_n)
    begin
      disp_on_q <= RST_DISP_ON;
      seg_nrm_q <= RST_SEG_NRM;
      invert_q  <= RST_INVERT;
      all_on_q  <= RST_ALL_ON;
      bias_q    <= RST_BIAS;
      psave_q   <= 1'b0;
    end
    else
    begin
      if (c_onoff) disp_on_q <= c[0];                // see [R3]
      if (c_adc)   seg_nrm_q <= ~c[0];               // see [R16]
      if (c_rev)   invert_q  <= c[0];                // see [R17]
      if (c_allon) all_on_q  <= c[0];                // see [R18]
      if (c_bias)  bias_q    <= c[0];                // see [R20]
      psave_q <= nxt_psave;
    end
  end

  // addressing state; column sets are ignored inside read-modify-write
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      start_q    <= RST_START;
      page_q     <= RST_PAGE;
      col_q      <= RST_COL;
      col_save_q <= RST_COL;
      rmw_q      <= 1'b0;
    end
    else if (!hw_rst_n || c_reset)
    begin
      start_q <= RST_START;                          // see [R24]
      page_q  <= RST_PAGE;
      col_q   <= RST_COL;
      rmw_q   <= 1'b0;
    end
    else
    begin
      if (c_start) start_q <= c[5:0];                // see [R5]
      if (c_page)  page_q  <= c[3:0];                // see [R6] [R7]
      if (c_rmw)
      begin
        rmw_q      <= 1'b1;
        col_save_q <= col_q;                         // see [R21]
      end
      if (c_end)
      begin
        rmw_q <= 1'b0;
        col_q <= col_save_q;                         // see [R22]
      end
      else if (c_colhi && !rmw_q)
        col_q <= {c[3:0], col_q[3:0]};               // see [R8] [R23]
      else if (c_collo && !rmw_q)
        col_q <= {col_q[7:4], c[3:0]};               // see [R8]
      else if (col_bump)
        col_q <= col_q + 8'd1;                       // see [R9] [R14]
    end
  end

  // read pipeline: ram data lands in the latch the host sees on its next read,
  // which is why the first read after a column set returns stale data
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      st_q     <= ST_IDLE;
      rd_lat_q <= RST_DATA;
      rd_ok_q  <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (dat_rd)
          begin
            st_q    <= ST_RD_WAIT;
            rd_ok_q <= col_ok;                       // column bumps on this same edge outside read-modify-write
          end
        end
        ST_RD_WAIT:
        begin
          rd_lat_q <= rd_ok_q ? ram_rd : RST_DATA;   // see [R15]
          st_q     <= ST_IDLE;
        end
      endcase
    end
  end

  // pin-facing outputs, all registered; enable low while driving
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_DATA      <= RST_DATA;
      O_DATA_OE_N <= 1'b1;
      O_BUSY      <= 1'b1;
      O_DISP      <= '0;
    end
    else
    begin
      if (rd_fall) O_DATA <= dcs ? rd_lat_q : status;  // see [R1] [R10]
      O_DATA_OE_N <= rd_n | cs_n | ser_mode;
      O_BUSY      <= busy;
      O_DISP      <= '{disp_on: disp_on_q, seg_normal: seg_nrm_q, invert: invert_q,
                       all_on: all_on_q, bias_alt: bias_q, power_save: psave_q,
                       start_line: start_q};
    end
  end

  // checks
  a_onoff_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R3]
    c_onoff && hw_rst_n |=> disp_on_q == $past(c[0])) else $error("display on/off not loaded");
  a_start_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R5]
    c_start && !c_reset && hw_rst_n |=> start_q == $past(c[5:0])) else $error("start line wrong");
  a_psave_on: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R4]
    hw_rst_n && !disp_on_q && all_on_q && !c_onoff && !c_allon |=> ##1 O_DISP.power_save)
    else $error("power save missed");
  a_col_write: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R14]
    dat_wr && col_ok && hw_rst_n |=> col_q == $past(col_q) + 8'd1) else $error("column not bumped");
  a_rmw_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R21]
    dat_rd && rmw_q && hw_rst_n |=> col_q == $past(col_q)) else $error("column moved on rmw read");
  a_end_restore: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R22]
    c_end && hw_rst_n |=> col_q == $past(col_save_q) && !rmw_q) else $error("column not restored");
  a_reset_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R24]
    c_reset |=> start_q == RST_START && page_q == RST_PAGE && col_q == RST_COL && !rmw_q
    && init_act) else $error("reset command incomplete");
  a_busy_stall: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R10]
    init_act |-> !take ##1 O_BUSY) else $error("command taken while busy");
  a_page_mask: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R6]
    ram_we && page_q == LAST_PAGE |-> ram_wd[7:1] == 7'h00) else $error("indicator page wide write");
  a_status_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // see [R13]
    rd_fall && !dcs |=> O_DATA[3:0] == 4'h0 && O_DATA[5] == $past(~disp_on_q)) else $error("status bits");
endmodule : lcdc_top

// ===== rtl/lcdc_pkg.sv
// shared constants and carriers of the lcd command decoder
// assumes one 100 MHz clock; host pins arrive unsynchronised
package lcdc_pkg;
  localparam int          CLK_MHZ     = 100;
  localparam int          INIT_NS     = 1000;                        // busy time after any reset
  localparam int          INIT_CYC    = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int          NUM_COLS    = 132;                         // columns 0..131, counter stops at 132
  localparam int          NUM_PAGES   = 9;                           // pages 0..7 plus indicator page 8
  localparam logic [3:0]  LAST_PAGE   = 4'h8;
  localparam logic [7:0]  COL_STOP    = 8'h84;                       // column 132
  localparam logic [3:0]  NIB_MAX     = 4'h8;
  // command codes and decode prefixes
  localparam logic [6:0]  PFX_ONOFF   = 7'h57;                       // AEh / AFh
  localparam logic [6:0]  PFX_ADC     = 7'h50;                       // A0h / A1h
  localparam logic [6:0]  PFX_BIAS    = 7'h51;                       // A2h / A3h
  localparam logic [6:0]  PFX_ALLON   = 7'h52;                       // A4h / A5h
  localparam logic [6:0]  PFX_REV     = 7'h53;                       // A6h / A7h
  localparam logic [1:0]  PFX_START   = 2'h1;                        // 40h..7Fh
  localparam logic [3:0]  PFX_PAGE    = 4'hB;
  localparam logic [3:0]  PFX_COLHI   = 4'h1;
  localparam logic [3:0]  PFX_COLLO   = 4'h0;
  localparam logic [7:0]  CMD_RMW     = 8'hE0;
  localparam logic [7:0]  CMD_END     = 8'hEE;
  localparam logic [7:0]  CMD_RESET   = 8'hE2;
  // reset values
  localparam logic        RST_DISP_ON = 1'b0;
  localparam logic        RST_SEG_NRM = 1'b1;
  localparam logic        RST_INVERT  = 1'b0;
  localparam logic        RST_ALL_ON  = 1'b0;
  localparam logic        RST_BIAS    = 1'b0;
  localparam logic [5:0]  RST_START   = 6'h00;
  localparam logic [3:0]  RST_PAGE    = 4'h0;
  localparam logic [7:0]  RST_COL     = 8'h00;
  localparam logic [7:0]  RST_DATA    = 8'h00;

  // one host transfer as queued for execution
  typedef struct packed {
    logic       is_data;   // data_command_select level
    logic       is_read;
    logic [7:0] byte_v;
  } lcdc_xfer_s;

  // display state handed to the panel timing logic
  typedef struct packed {
    logic       disp_on;
    logic       seg_normal;
    logic       invert;
    logic       all_on;
    logic       bias_alt;
    logic       power_save;
    logic [5:0] start_line;
  } lcdc_disp_s;
endpackage : lcdc_pkg

// ===== rtl/lcdc_ram.sv
// display ram: single port, read data registered
// assumes address is always below DEPTH
`timescale 1ns/1ps
module lcdc_ram #(
  parameter int DEPTH = 1188,
  parameter int AW    = 11,
  parameter int DW    = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];

  // no reset on the array: contents survive every reset
  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
    o_rdata <= mem[i_addr];
  end
endmodule : lcdc_ram

// ===== rtl/lcdc_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock; full and empty are exact
`timescale 1ns/1ps
module lcdc_buf2 #(
  parameter int W = 10
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  logic [W-1:0] slot_q [2];
  logic         rd_q, wr_q;
  logic [1:0]   cnt_q;
  wire          push = i_in_valid && o_in_ready;
  wire          pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_q != 2'd2);
  assign o_out_valid = (cnt_q != 2'd0);
  assign o_out_data  = slot_q[rd_q];

  // pointers and count; slots hold no reset since count guards them
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push) wr_q <= ~wr_q;
      if (pop)  rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      slot_q[wr_q] <= i_in_data;
  end
endmodule : lcdc_buf2

// ===== tb/lcdc_host.sv
// host processor model for the lcd command decoder pins
// assumes the bench calls its tasks one at a time; pins move after a rising edge
`timescale 1ns/1ps
module lcdc_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_cs_n,
  output logic            o_dcs,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [7:0] o_data,
  output logic            o_scl,
  output logic            o_sdi,
  output logic            o_got,
  output logic      [7:0] o_val
);
  // idle pins: strobes high, serial clock parked high between frames
  initial
  begin
    o_cs_n = 1'b1;
    o_dcs  = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 8'h00;
    o_scl  = 1'b1;
    o_sdi  = 1'b0;
    o_got  = 1'b0;
    o_val  = 8'h00;
  end

  // parallel write; strobes kept 4 cycles so the 2-flop sync sees them
  task wr(input logic dcs, input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dcs  <= dcs;
    o_data <= b;
    o_wr_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_wr_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_data <= ~b;     // released bus shows no stale value
    repeat (3) @(posedge i_clk);
  endtask : wr

  // parallel read; chk low marks a dummy read whose byte is thrown away
  task rd(input logic dcs, input logic chk);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dcs  <= dcs;
    o_rd_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_val  <= i_rdata;
    o_got  <= chk;
    @(posedge i_clk);
    o_got  <= 1'b0;
    o_rd_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    @(posedge i_clk);
  endtask : rd

  // serial write, most significant bit first
  task swr(input logic dcs, input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dcs  <= dcs;
    repeat (4) @(posedge i_clk);
    for (int i = 7; i >= 0; i--)
    begin
      o_sdi <= b[i];
      o_scl <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_sdi  <= ~b[0];
    repeat (4) @(posedge i_clk);
  endtask : swr
endmodule : lcdc_host

// ===== tb/lcd_controller_command_decoder_bench.sv
// self-checking bench of the lcd command decoder
// assumes lcdc_top with its package; lcdc_host plays the processor
`timescale 1ns/1ps
module lcd_controller_command_decoder_bench;
  import lcdc_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_n  = 1'b1;
  logic        ser   = 1'b0;
  logic        probe = 1'b0;
  logic        cs_n, dcs, rd_n, wr_n, scl, sdi, got, oe_n, busy;
  logic [7:0]  wdat, rdata, val;
  lcdc_disp_s  disp;
  lcdc_disp_s  e;
  logic [7:0]  d [4];
  logic [15:0] expq [$];
  int          fail_count = 0;
  int          n_checks   = 0;
  localparam logic [7:0] CL [16] = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hA3, 8'h7F, 8'hAE, 8'hA4,
                                     8'hA5, 8'hA0, 8'hA6, 8'hA2, 8'hA4, 8'hAF, 8'h40, 8'hFF};

  always #5 clk = ~clk;

  lcdc_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HARDWARE_RESET_N(hw_n), .I_SERIAL_MODE(ser),
    .I_CS_N(cs_n), .I_DATA_COMMAND_SELECT(dcs), .I_RD_N(rd_n), .I_WR_N(wr_n), .I_DATA(wdat),
    .I_SCL(scl), .I_SDI(sdi), .O_DATA(rdata), .O_DATA_OE_N(oe_n), .O_BUSY(busy), .O_DISP(disp));

  lcdc_host host (.i_clk(clk), .i_rdata(rdata), .o_cs_n(cs_n), .o_dcs(dcs), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_data(wdat), .o_scl(scl), .o_sdi(sdi), .o_got(got), .o_val(val));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    if (expq.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task exp_rd(input logic [7:0] v);
    expq.push_back({8'h00, v});
  endtask : exp_rd

  // snapshot of the display state, taken by the watcher one edge later
  task chk_disp;
    expq.push_back({4'h0, e});
    @(posedge clk);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask : chk_disp

  function automatic logic [7:0] stat(input logic bsy, input logic ini);
    return {bsy, e.seg_normal, ~e.disp_on, ini, 4'h0};
  endfunction : stat

  // expected display state follows every command sent except E2h, whose start line clear the caller sets
  task cmd(input logic [7:0] c);
    host.wr(1'b0, c);
    case (c) inside
      8'hAE, 8'hAF:  e.disp_on    = c[0];
      8'hA0, 8'hA1:  e.seg_normal = ~c[0];
      8'hA6, 8'hA7:  e.invert     = c[0];
      8'hA4, 8'hA5:  e.all_on     = c[0];
      8'hA2, 8'hA3:  e.bias_alt   = c[0];
      [8'h40:8'h7F]: e.start_line = c[5:0];
      default:       ;
    endcase
    e.power_save = ~e.disp_on & e.all_on;
  endtask : cmd

  task setcol(input logic [7:0] c);
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask : setcol

  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 400)
    begin
      fail_count++;
      $display("BAD %0t busy never dropped", $time);
      end_of_test;
    end
  endtask : wait_idle

  // watcher: every result met pairs with the oldest note
  always @(posedge clk)
  begin
    if (got === 1'b1 || probe === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        fail_count++;
        $display("BAD %0t result without note", $time);
      end
      else
        check((got === 1'b1) ? {8'h00, val} : {4'h0, disp}, expq.pop_front());
      // data pins driven only while a parallel read strobe stands
      check({15'h0000, oe_n}, (got === 1'b1) ? 16'h0000 : 16'h0001);
    end
  end

  // hang guard, well above the longest sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("BAD %0t run too long", $time);
    end_of_test;
  end

  initial
  begin
    void'($urandom(95));
    for (int i = 0; i < 4; i++)
      d[i] = 8'($urandom);
    e = '0;
    e.seg_normal = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // three writes while initialising: buffer takes two, refuses the third
    for (int i = 1; i < 4; i++)
      host.wr(1'b0, 8'(8'h40 + i));
    exp_rd(stat(1'b1, 1'b1));
    host.rd(1'b0, 1'b1);
    wait_idle;
    e.start_line = 6'h02;
    chk_disp;
    // every display mode command, with status after each
    foreach (CL[i])
    begin
      cmd(CL[i]);
      chk_disp;
      exp_rd(stat(1'b0, 1'b0));
      host.rd(1'b0, 1'b1);
    end
    // ram write, dummy read, read back; page change leaves display alone
    cmd(8'hB2);
    chk_disp;
    setcol(8'h05);
    for (int i = 0; i < 3; i++)
      host.wr(1'b1, d[i]);
    setcol(8'h05);
    host.rd(1'b1, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      exp_rd(d[i]);
      host.rd(1'b1, 1'b1);
    end
    // read-modify-write: reads hold the column, end returns to it
    setcol(8'h05);
    cmd(8'hE0);
    host.rd(1'b1, 1'b0);
    exp_rd(d[0]);
    host.rd(1'b1, 1'b1);
    host.wr(1'b1, d[3]);
    host.wr(1'b1, ~d[3]);
    cmd(CMD_END);
    host.rd(1'b1, 1'b0);
    exp_rd(d[3]);
    host.rd(1'b1, 1'b1);
    exp_rd(~d[3]);
    host.rd(1'b1, 1'b1);
    // last column, then the counter stops at 132
    setcol(8'h83);
    host.wr(1'b1, d[1]);
    host.wr(1'b1, d[2]);
    setcol(8'h83);
    host.rd(1'b1, 1'b0);
    exp_rd(d[1]);
    host.rd(1'b1, 1'b1);
    exp_rd(8'h00);
    host.rd(1'b1, 1'b1);
    // indicator page keeps bit 0 only
    cmd(8'hB8);
    setcol(8'h00);
    host.wr(1'b1, 8'hFF);
    setcol(8'h00);
    host.rd(1'b1, 1'b0);
    exp_rd(8'h01);
    host.rd(1'b1, 1'b1);
    // soft reset clears addressing and start line, keeps ram and modes
    cmd(8'h45);
    cmd(8'hB3);
    setcol(8'h07);
    cmd(CMD_RESET);
    e.start_line = 6'h00;
    exp_rd(stat(1'b1, 1'b1));
    host.rd(1'b0, 1'b1);
    wait_idle;
    chk_disp;
    host.wr(1'b1, d[2]);
    cmd(8'hB0);
    setcol(8'h00);
    host.rd(1'b1, 1'b0);
    exp_rd(d[2]);
    host.rd(1'b1, 1'b1);
    cmd(8'hB2);
    setcol(8'h05);
    host.rd(1'b1, 1'b0);
    exp_rd(d[3]);
    host.rd(1'b1, 1'b1);
    // reset pin restores all defaults
    cmd(8'hA1);
    cmd(8'hA7);
    @(posedge clk);
    hw_n <= 1'b0;
    repeat (5) @(posedge clk);
    hw_n <= 1'b1;
    e = '0;
    e.seg_normal = 1'b1;
    repeat (4) @(posedge clk);
    wait_idle;
    chk_disp;
    // serial commands; bit-reversed forms would decode as nothing
    @(posedge clk);
    ser <= 1'b1;
    repeat (4) @(posedge clk);
    host.swr(1'b0, 8'h4B);
    host.swr(1'b0, 8'hA7);
    e.start_line = 6'h0B;
    e.invert = 1'b1;
    chk_disp;
    repeat (20) @(posedge clk);
    end_of_test;
  end
endmodule : lcd_controller_command_decoder_bench
